// ### rtl/wtcc_pkg.sv
// Shared constants and state types for the write-through cache controller.
// Assumes word addresses A31..A2 arrive from the processor side.
package wtcc_pkg;
  // ---------------------------------------------------------------
  // Directory shape and address fields
  // ---------------------------------------------------------------
  localparam int DIR_ENTRIES = 1024;
  localparam int SETS = 512;
  localparam int LINES = 8;
  localparam int ENT_W = 10;
  localparam int SET_W = 9;
  localparam int TAG_W = 18;
  localparam int LINE_LSB = 2;
  localparam int LINE_MSB = 4;
  localparam int SET_LSB = 5;
  localparam int SET_MSB = 13;
  localparam int DM_WAY_BIT = 14;
  localparam int TAG_LSB = 14;
  localparam int DM_TAG_LSB = 15;
  // ---------------------------------------------------------------
  // Strobe reset values and bank selects (active high selects)
  // ---------------------------------------------------------------
  localparam logic STROBE_OFF = 1'h1;
  localparam logic [1:0] BANKS_OFF_N = 2'h3;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;
  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {C_IDLE, C_RDWAIT, C_WRWAIT} wtcc_cpu_state_t;
  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_CYCLE} wtcc_bus_state_t;
endpackage

// ### rtl/wtcc_dir.sv
// Tag directory: 1024 entries seen as two ways of 512 sets, LRU per set.
// Assumes at most one fill or touch and one snoop invalidate per cycle.
`timescale 1ns/1ps
module wtcc_dir
  import wtcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Mode
  input wire logic two_way_i,
  // Lookup
  input wire logic [31:2] look_addr_i,
  output logic look_hit_o,
  output logic look_way_o,
  output logic victim_o,
  // Update
  input wire logic fill_en_i,
  input wire logic touch_en_i,
  input wire logic [31:2] upd_addr_i,
  input wire logic upd_way_i,
  // Snoop
  input wire logic snoop_en_i,
  input wire logic [31:2] snoop_addr_i
);
  logic [TAG_W-1:0] tag_mem [0:DIR_ENTRIES-1]; // RL23
  logic [LINES:0] vld_mem [0:DIR_ENTRIES-1];
  logic [SETS-1:0] lru_reg;
  logic [1:0] look_hit;
  logic [1:0] snp_hit;
  logic [ENT_W-1:0] ue;
  logic [LINES-1:0] uhot;
  logic new_tag;

  // Top bit of an entry flags tag valid; low bits are line valids
  function automatic logic match(input logic [TAG_W-1:0] t,
      input logic [LINES:0] v, input logic [31:2] a, input logic tw);
    logic tag_eq;
    tag_eq = tw ? (t == a[31:TAG_LSB]) // RL5
                : (t[TAG_W-1:1] == a[31:DM_TAG_LSB]); // RL6
    return v[LINES] && v[a[LINE_MSB:LINE_LSB]] && tag_eq;
  endfunction

  // ---------------------------------------------------------------
  // Per-way compare
  // ---------------------------------------------------------------
  // Direct mode: A14 picks the half, so one tag is compared
  for (genvar g = 0; g < 2; g++) begin : g_way
    logic [ENT_W-1:0] le;
    logic [ENT_W-1:0] se;
    logic way_ok_l;
    logic way_ok_s;
    assign le = {1'(g), look_addr_i[SET_MSB:SET_LSB]};
    assign se = {1'(g), snoop_addr_i[SET_MSB:SET_LSB]};
    assign way_ok_l = two_way_i || look_addr_i[DM_WAY_BIT] == 1'(g); // RL7
    assign way_ok_s = two_way_i || snoop_addr_i[DM_WAY_BIT] == 1'(g);
    assign look_hit[g] = way_ok_l &&
        match(tag_mem[le], vld_mem[le], look_addr_i, two_way_i); // RL1 RL3
    assign snp_hit[g] = way_ok_s &&
        match(tag_mem[se], vld_mem[se], snoop_addr_i, two_way_i);
  end

  assign look_hit_o = |look_hit;
  assign look_way_o = look_hit[1];
  assign victim_o = two_way_i ? lru_reg[look_addr_i[SET_MSB:SET_LSB]]
                              : look_addr_i[DM_WAY_BIT]; // RL27
  assign ue = {upd_way_i, upd_addr_i[SET_MSB:SET_LSB]};
  assign uhot = LINES'(1) << upd_addr_i[LINE_MSB:LINE_LSB];
  assign new_tag = !vld_mem[ue][LINES] ||
                   tag_mem[ue] != upd_addr_i[31:TAG_LSB];

  // ---------------------------------------------------------------
  // Valid bits, tags and LRU
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DIR_ENTRIES; i++) begin
        vld_mem[i] <= '0; // RL28
      end
    end else begin
      for (int w = 0; w < 2; w++) begin
        if (snoop_en_i && snp_hit[w]) begin
          vld_mem[{1'(w), snoop_addr_i[SET_MSB:SET_LSB]}]
              [snoop_addr_i[LINE_MSB:LINE_LSB]] <= 1'h0; // RL25
        end
      end
      // Fill wins over a snoop of the same line: data is fresh
      if (fill_en_i) begin
        if (new_tag) begin
          vld_mem[ue] <= {1'h1, uhot}; // RL24
        end else begin
          vld_mem[ue] <= vld_mem[ue] | {1'h1, uhot};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (fill_en_i) begin
      tag_mem[ue] <= upd_addr_i[31:TAG_LSB];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lru_reg <= '0;
    end else if (touch_en_i && two_way_i) begin
      lru_reg[upd_addr_i[SET_MSB:SET_LSB]] <= !upd_way_i; // RL27
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_fill_clears: assert property (fill_en_i && new_tag |=> // RL24
      vld_mem[$past(ue)] == {1'h1, $past(uhot)})
    else $error("fill with new tag kept stale line valids");
  chk_snoop_inval: assert property (snoop_en_i && snp_hit[0] && // RL25
      !fill_en_i |=> !vld_mem[{1'h0, $past(snoop_addr_i[SET_MSB:SET_LSB])}]
      [$past(snoop_addr_i[LINE_MSB:LINE_LSB])])
    else $error("snoop hit did not invalidate line");
  chk_dm_single: assert property (!two_way_i |-> look_hit != 2'h3) // RL3
    else $error("direct mode compared two tags");
endmodule // wtcc_dir

// ### rtl/wtcc_ctrl.sv
// Write-through cache controller: processor side, SRAM strobes, system bus.
// Assumes external address latch, SRAM and bridge registers; no data path.
//
// Notes on behaviour
// RL1: 2-way: compare both banks; strobe only the hit bank.
// RL2: Output enable may also be active during write hits.
// RL3: Direct mode: one 8Kx32 store, 1024 entries, one tag compared.
// RL4: Direct mode: both banks get identical strobes together.
// RL5: 2-way: set A5-A13, line A2-A4, tag A14-A31.
// RL6: Direct: line A2-A4, index A5-A14, tag A15-A31.
// RL7: Field remap follows mode input; address pins unchanged.
// RL8: Address strobe clock: latch enable pulses, hit or miss decided.
// RL9: Miss: clock and enable bridge address, data, status registers.
// RL10: System strobe trails processor strobe; system ready ends it.
// RL11: Miss asserts next-address request to the processor.
// RL12: Early next address is looked up; its cycle launches right after.
// RL13: No next-address request during cache hits; code still requests one for a write hit held by a busy bus.
// RL14: Read miss holds processor; returning data fills cache same cycle.
// RL15: Every write goes to main memory.
// RL16: Posted write: ready on the clock after the address strobe.
// RL17: Posted write waits for bus; its system ready is absorbed.
// RL18: Only one write posted at a time.
// RL19: Write hit also updates the cache, possibly before memory.
// RL20: Write miss never allocates; only read misses fill.
// RL21: Read hit: cache data enabled on the next clock.
// RL22: Read hit starts no system bus cycle.
// RL23: 2-way: 512 tags per bank, each over eight lines.
// RL24: Entry has tag valid and eight line valids; new tag clears others.
// RL25: Snooped foreign writes invalidate matching lines.
// RL26: Local, non-cacheable or narrow flags make an access uncached.
// RL27: 2-way read miss replaces per-set LRU bank.
// RL28: Reset clears all valid bits.
`timescale 1ns/1ps
module wtcc_ctrl
  import wtcc_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // Mode
  input wire logic ASSOC_2WAY_I,
  // Processor request
  input wire logic CPU_ADDR_STROBE_N_I,
  input wire logic [31:2] CPU_ADDR_I,
  input wire logic CPU_WRITE_I,
  // Address decoder flags
  input wire logic LOCAL_SPACE_N_I,
  input wire logic NONCACHEABLE_N_I,
  input wire logic NARROW_MEM_N_I,
  // Processor answers
  output logic CPU_READY_N_O,
  output logic NEXT_ADDR_REQ_N_O,
  // Cache SRAM control
  output logic CACHE_ADDR_LATCH_EN_O,
  output logic [1:0] CACHE_OUT_EN_N_O,
  output logic [1:0] CACHE_WR_EN_N_O,
  // Bridge registers
  output logic BRIDGE_CLK_EN_O,
  output logic BRIDGE_OUT_EN_O,
  // System bus
  input wire logic SYS_BUS_FREE_I,
  output logic SYS_ADDR_STROBE_N_O,
  input wire logic SYS_READY_N_I,
  // Snoop
  input wire logic SNOOP_WRITE_I,
  input wire logic [31:2] SNOOP_ADDR_I
);
  wtcc_cpu_state_t cpu_state;
  wtcc_bus_state_t bus_state;
  logic pend_reg, pend_write_reg, pend_unc_reg;
  logic [31:2] pend_addr_reg, cur_addr_reg, req_addr, look_addr;
  logic cur_write_reg, cur_unc_reg, cur_vict_reg, issued_reg, job_wr_reg;
  logic unc_now, in_idle, take, req_write, req_unc;
  logic look_hit, look_way, victim, lk_unc, chit, bus_free;
  logic rd_hit_go, rd_miss_go, wr_go, wr_hold, rd_job, job_start;
  logic rd_done, fill_en, touch_en, bus_out_next;
  logic [1:0] hit_sel, fill_sel, oe_sel, we_sel;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  assign unc_now = !LOCAL_SPACE_N_I || !NONCACHEABLE_N_I ||
                   !NARROW_MEM_N_I; // RL26
  assign in_idle = cpu_state == C_IDLE;
  // A pipelined address waiting in the pending latch goes first
  assign take = in_idle && (pend_reg || !CPU_ADDR_STROBE_N_I); // RL8
  assign req_addr = pend_reg ? pend_addr_reg : CPU_ADDR_I;
  assign req_write = pend_reg ? pend_write_reg : CPU_WRITE_I;
  assign req_unc = pend_reg ? pend_unc_reg : unc_now;
  // Held writes recheck the tag at launch: a snoop may have hit
  assign look_addr = in_idle ? req_addr : cur_addr_reg;
  assign lk_unc = in_idle ? req_unc : cur_unc_reg;
  assign chit = look_hit && !lk_unc; // RL26
  assign bus_free = bus_state == B_IDLE;

  assign rd_hit_go = take && !req_write && chit; // RL22
  assign rd_miss_go = take && !req_write && !chit;
  assign wr_go = bus_free && ((take && req_write) ||
                 cpu_state == C_WRWAIT); // RL18
  assign wr_hold = take && req_write && !bus_free;
  assign rd_job = cpu_state == C_RDWAIT && bus_free && !issued_reg;
  assign job_start = wr_go || rd_job; // RL15
  assign rd_done = bus_state == B_CYCLE && !SYS_READY_N_I &&
                   !job_wr_reg;
  assign fill_en = rd_done && !cur_unc_reg; // RL20
  assign touch_en = fill_en || rd_hit_go || (wr_go && chit);

  // Direct mode drives both banks alike
  assign hit_sel = !ASSOC_2WAY_I ? SEL_BOTH :
                   (look_way ? SEL_B : SEL_A); // RL1 RL4
  assign fill_sel = !ASSOC_2WAY_I ? SEL_BOTH :
                    (cur_vict_reg ? SEL_B : SEL_A);
  // Output enable rides along on write hits; SRAM must tolerate it
  assign oe_sel = (rd_hit_go || (wr_go && chit)) ? hit_sel
                                                 : SEL_NONE; // RL2 RL21
  assign we_sel = (wr_go && chit) ? hit_sel : // RL19
                  (fill_en ? fill_sel : SEL_NONE); // RL14

  // ---------------------------------------------------------------
  // Directory
  // ---------------------------------------------------------------
  wtcc_dir u_wtcc_dir (
    .clk_i(MCLK_I),
    .rst_n_i(RESET_N_I),
    .two_way_i(ASSOC_2WAY_I),
    .look_addr_i(look_addr),
    .look_hit_o(look_hit),
    .look_way_o(look_way),
    .victim_o(victim),
    .fill_en_i(fill_en),
    .touch_en_i(touch_en),
    .upd_addr_i(look_addr),
    .upd_way_i(fill_en ? cur_vict_reg : look_way),
    .snoop_en_i(SNOOP_WRITE_I),
    .snoop_addr_i(SNOOP_ADDR_I)
  );

  // ---------------------------------------------------------------
  // Pending address latch for pipelined cycles
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pend_reg <= 1'h0;
      pend_write_reg <= 1'h0;
      pend_unc_reg <= 1'h0;
      pend_addr_reg <= '0;
    end else if (!CPU_ADDR_STROBE_N_I && !(take && !pend_reg)) begin
      pend_reg <= 1'h1; // RL12
      pend_write_reg <= CPU_WRITE_I;
      pend_unc_reg <= unc_now;
      pend_addr_reg <= CPU_ADDR_I;
    end else if (take) begin
      pend_reg <= 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // Current reference
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cur_write_reg <= 1'h0;
      cur_unc_reg <= 1'h0;
      cur_addr_reg <= '0;
    end else if (take) begin
      cur_write_reg <= req_write;
      cur_unc_reg <= req_unc;
      cur_addr_reg <= req_addr;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cur_vict_reg <= 1'h0;
    end else if (rd_miss_go) begin
      cur_vict_reg <= victim; // RL27
    end
  end

  // ---------------------------------------------------------------
  // Processor-side sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cpu_state <= C_IDLE;
    end else begin
      case (cpu_state)
        C_IDLE: begin
          if (rd_miss_go) begin
            cpu_state <= C_RDWAIT;
          end else if (wr_hold) begin
            cpu_state <= C_WRWAIT;
          end
        end
        C_RDWAIT: begin
          if (rd_done) begin
            cpu_state <= C_IDLE; // RL14
          end
        end
        C_WRWAIT: begin
          if (wr_go) begin
            cpu_state <= C_IDLE;
          end
        end
        default: begin
          cpu_state <= C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      issued_reg <= 1'h0;
    end else if (rd_miss_go) begin
      issued_reg <= 1'h0;
    end else if (rd_job) begin
      issued_reg <= 1'h1;
    end
  end

  // ---------------------------------------------------------------
  // System bus sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bus_state <= B_IDLE;
    end else begin
      case (bus_state)
        B_IDLE: begin
          if (job_start) begin
            bus_state <= B_WAIT;
          end
        end
        B_WAIT: begin
          if (SYS_BUS_FREE_I) begin
            bus_state <= B_CYCLE; // RL17
          end
        end
        B_CYCLE: begin
          if (!SYS_READY_N_I) begin
            bus_state <= B_IDLE; // RL10
          end
        end
        default: begin
          bus_state <= B_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      job_wr_reg <= 1'h0;
    end else if (job_start) begin
      job_wr_reg <= wr_go;
    end
  end

  assign bus_out_next = job_start || (!bus_free &&
      !(bus_state == B_CYCLE && !SYS_READY_N_I));

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SYS_ADDR_STROBE_N_O <= STROBE_OFF;
      BRIDGE_CLK_EN_O <= 1'h0;
      BRIDGE_OUT_EN_O <= 1'h0;
    end else begin
      SYS_ADDR_STROBE_N_O <= !(bus_state == B_WAIT &&
                               SYS_BUS_FREE_I); // RL10
      BRIDGE_CLK_EN_O <= job_start; // RL9
      BRIDGE_OUT_EN_O <= bus_out_next; // RL9
    end
  end

  // ---------------------------------------------------------------
  // Processor and SRAM strobes
  // ---------------------------------------------------------------
  // System ready of a posted write never reaches the processor
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CPU_READY_N_O <= STROBE_OFF;
      NEXT_ADDR_REQ_N_O <= STROBE_OFF;
      CACHE_ADDR_LATCH_EN_O <= 1'h0;
    end else begin
      CPU_READY_N_O <= !(rd_hit_go || wr_go || rd_done); // RL16 RL17
      NEXT_ADDR_REQ_N_O <= !(rd_miss_go || wr_hold); // RL11 RL13
      CACHE_ADDR_LATCH_EN_O <= take; // RL8
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CACHE_OUT_EN_N_O <= BANKS_OFF_N;
      CACHE_WR_EN_N_O <= BANKS_OFF_N;
    end else begin
      CACHE_OUT_EN_N_O <= ~oe_sel;
      CACHE_WR_EN_N_O <= ~we_sel;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking dcb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_post_start;
    !CPU_READY_N_O && BRIDGE_CLK_EN_O ##1 CPU_READY_N_O;
  endsequence
  sequence s_fill_end;
    !CPU_READY_N_O && CACHE_WR_EN_N_O != BANKS_OFF_N;
  endsequence

  chk_cache_addr_latch_en_take: assert property (take |=> CACHE_ADDR_LATCH_EN_O) // RL8
    else $error("latch enable missing after address strobe");
  chk_rdhit_serve: assert property (rd_hit_go |=> // RL21
      !CPU_READY_N_O && CACHE_OUT_EN_N_O != BANKS_OFF_N)
    else $error("read hit not served on next clock");
  chk_rdhit_nobus: assert property (rd_hit_go && bus_free |=> // RL22
      bus_free && SYS_ADDR_STROBE_N_O)
    else $error("read hit started a system cycle");
  chk_post_ready: assert property (wr_go && take |=> // RL16
      s_post_start)
    else $error("posted write ready not after strobe");
  chk_write_through: assert property (wr_go |=> // RL15
      bus_state == B_WAIT)
    else $error("write not sent to memory");
  chk_sys_absorb: assert property (bus_state == B_CYCLE && job_wr_reg && // RL17
      !SYS_READY_N_I && !rd_hit_go && !wr_go |=> CPU_READY_N_O)
    else $error("posted write ready leaked to processor");
  chk_one_post: assert property (wr_hold |=> CPU_READY_N_O && // RL18
      cpu_state == C_WRWAIT)
    else $error("second job while bus busy");
  chk_na_miss: assert property (rd_miss_go |=> !NEXT_ADDR_REQ_N_O) // RL11
    else $error("no next-address request on miss");
  chk_na_hit: assert property (rd_hit_go |=> NEXT_ADDR_REQ_N_O) // RL13
    else $error("next-address request during hit");
  chk_fill_ready: assert property (fill_en |=> s_fill_end) // RL14
    else $error("fill not with processor ready");
  chk_wmiss_nofill: assert property (wr_go && !chit |=> // RL20
      CACHE_WR_EN_N_O == BANKS_OFF_N)
    else $error("write miss wrote the cache");
  chk_dm_same: assert property (!$past(ASSOC_2WAY_I) |-> // RL4
      CACHE_OUT_EN_N_O[0] == CACHE_OUT_EN_N_O[1] &&
      CACHE_WR_EN_N_O[0] == CACHE_WR_EN_N_O[1])
    else $error("direct mode bank strobes differ");
  chk_2way_one: assert property ($past(ASSOC_2WAY_I) |-> // RL1
      CACHE_OUT_EN_N_O != 2'h0 && CACHE_WR_EN_N_O != 2'h0)
    else $error("both banks strobed in 2-way mode");
  chk_sys_addr_strobe_n_lag: assert property (job_start |=> SYS_ADDR_STROBE_N_O) // RL10
    else $error("system strobe not trailing");
  chk_bridge_miss: assert property (rd_job |=> // RL9
      BRIDGE_CLK_EN_O && BRIDGE_OUT_EN_O)
    else $error("bridge not driven on miss");
  chk_unc_miss: assert property (take && req_unc && !req_write |=> // RL26
      CPU_READY_N_O)
    else $error("uncached read served from cache");
  chk_pipe_launch: assert property (rd_done && pend_reg |=> take) // RL12
    else $error("pipelined cycle not launched");
endmodule // wtcc_ctrl

// ### dv/wtcc_mem_model.sv
// System bus and main memory model for the cache controller bench.
// Assumes one system cycle at a time, opened by a one-cycle strobe.
`timescale 1ns/1ps
module wtcc_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench controls: wait states, another master owning the bus
  input wire logic [3:0] waits_i,
  input wire logic hold_bus_i,
  // System bus
  input wire logic sys_addr_strobe_n_i,
  output logic sys_bus_free_o,
  output logic sys_ready_n_o
);
  logic [3:0] cnt_reg;
  logic busy_reg;
  assign sys_bus_free_o = !hold_bus_i;
  // Ready idles high, as the pull-up on the real line would leave it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sys_ready_n_o <= 1'b1;
    end else begin
      sys_ready_n_o <= 1'b1;
      if (!sys_addr_strobe_n_i) begin
        busy_reg <= 1'b1;
        cnt_reg <= waits_i;
      end else if (busy_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        sys_ready_n_o <= 1'b0;
      end
    end
  end
endmodule // wtcc_mem_model

// ### dv/wtcc_ctrl_test.sv
// Self-checking bench for the cache controller, one task per scenario.
// Assumes the memory model answers every system strobe.
`timescale 1ns/1ps
module wtcc_ctrl_test
  import wtcc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic two_way = 1'b1;
  logic as_n = 1'b1;
  logic wr = 1'b0;
  logic snp = 1'b0;
  logic hold = 1'b0;
  logic [2:0] fl = 3'h7;
  logic [3:0] waits = 4'h2;
  logic [31:2] addr = 30'h0;
  logic [31:2] snp_a = 30'h0;
  // A14 is value bit 12, A15 is value bit 13
  logic [31:2] a0 = 30'h0123456;
  logic rdy_n, na_n, cale, bclk, boe, free, sys_addr_strobe_n_n, brdy_n;
  logic [1:0] oe_n, we_n;
  logic [1:0] oe_s = 2'h0;
  logic [1:0] we_s = 2'h0;
  int n_sys, n_rdy, n_na, n_cale, n_bclk, fails, n_checks, lat;

  always #50 clk = ~clk;

  wtcc_ctrl u_wtcc_ctrl (.MCLK_I(clk), .RESET_N_I(rst_n),
    .ASSOC_2WAY_I(two_way), .CPU_ADDR_STROBE_N_I(as_n),
    .CPU_ADDR_I(addr), .CPU_WRITE_I(wr), .LOCAL_SPACE_N_I(fl[2]),
    .NONCACHEABLE_N_I(fl[1]), .NARROW_MEM_N_I(fl[0]),
    .CPU_READY_N_O(rdy_n), .NEXT_ADDR_REQ_N_O(na_n),
    .CACHE_ADDR_LATCH_EN_O(cale), .CACHE_OUT_EN_N_O(oe_n),
    .CACHE_WR_EN_N_O(we_n), .BRIDGE_CLK_EN_O(bclk),
    .BRIDGE_OUT_EN_O(boe), .SYS_BUS_FREE_I(free),
    .SYS_ADDR_STROBE_N_O(sys_addr_strobe_n_n), .SYS_READY_N_I(brdy_n),
    .SNOOP_WRITE_I(snp), .SNOOP_ADDR_I(snp_a));
  wtcc_mem_model u_wtcc_mem_model (.clk_i(clk), .rst_n_i(rst_n),
    .waits_i(waits), .hold_bus_i(hold), .sys_addr_strobe_n_i(sys_addr_strobe_n_n),
    .sys_bus_free_o(free), .sys_ready_n_o(brdy_n));

  // Strobes are pulses, so they are gathered over the whole reference
  always @(posedge clk) begin
    oe_s <= oe_s | ~oe_n;
    we_s <= we_s | ~we_n;
    n_sys <= n_sys + int'(sys_addr_strobe_n_n === 1'b0);
    n_rdy <= n_rdy + int'(rdy_n === 1'b0);
    n_na <= n_na + int'(na_n === 1'b0);
    n_cale <= n_cale + int'(cale === 1'b1);
    n_bclk <= n_bclk + int'(bclk === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic rst(input logic m);
    @(posedge clk);
    rst_n <= 1'b0;
    two_way <= m;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // One processor reference; dr waits for the system job to drain
  task automatic cref(input logic [31:2] a, input logic w,
                      input logic [2:0] f, input logic dr);
    int n;
    @(negedge clk);
    oe_s = 2'h0;
    we_s = 2'h0;
    {n_sys, n_rdy, n_na, n_cale, n_bclk} = '0;
    @(posedge clk);
    as_n <= 1'b0;
    addr <= a;
    wr <= w;
    fl <= f;
    @(posedge clk);
    as_n <= 1'b1;
    lat = 0;
    n = 0;
    while (rdy_n !== 1'b0 && lat < 40) begin
      @(posedge clk);
      lat++;
    end
    while (dr && boe !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (lat >= 40 || n >= 40) begin
      fails++;
      results();
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic t_two_way;
    rst(1'b1);
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(lat >= 4, 1);
    chk(n_na, 1);
    chk(n_bclk, 1);
    chk(n_sys, 1);
    chk(n_cale, 1);
    chk(we_s, SEL_A);
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(lat, 1);
    chk(oe_s, SEL_A);
    chk(n_sys + n_na, 0);
    cref(a0 ^ 30'h1000, 1'b0, 3'h7, 1'b1);
    chk(we_s, SEL_B);
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(oe_s, SEL_A);
    $display("two-way test done");
  endtask

  task automatic t_direct;
    rst(1'b0);
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(we_s, SEL_BOTH);
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(oe_s, SEL_BOTH);
    cref(a0 ^ 30'h1000, 1'b0, 3'h7, 1'b1);
    chk(n_sys, 1);
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(n_sys, 0);
    cref(a0 ^ 30'h2000, 1'b0, 3'h7, 1'b1);
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(n_sys, 1);
    $display("direct test done");
  endtask

  task automatic t_write;
    rst(1'b1);
    waits <= 4'h6;
    cref(a0, 1'b0, 3'h7, 1'b1);
    cref(a0, 1'b1, 3'h7, 1'b1);
    chk(lat, 1);
    chk(n_rdy, 1);
    chk(n_sys, 1);
    chk(we_s, SEL_A);
    chk(oe_s, SEL_A);
    cref(a0 ^ 30'h2000, 1'b1, 3'h7, 1'b1);
    chk(we_s, SEL_NONE);
    chk(n_sys, 1);
    cref(a0 ^ 30'h2000, 1'b0, 3'h7, 1'b1);
    chk(n_sys, 1);
    hold <= 1'b1;
    cref(a0, 1'b1, 3'h7, 1'b0);
    chk(n_sys, 0);
    hold <= 1'b0;
    cref(a0, 1'b1, 3'h7, 1'b1);
    chk(lat > 2, 1);
    chk(n_na, 1);
    $display("write test done");
  endtask

  task automatic t_misc;
    rst(1'b1);
    cref(a0, 1'b0, 3'h7, 1'b1);
    for (int i = 0; i < 3; i++) begin
      cref(a0, 1'b0, ~(3'h1 << i), 1'b1);
      chk(n_sys, 1);
      chk(we_s, SEL_NONE);
    end
    @(posedge clk);
    snp <= 1'b1;
    snp_a <= a0;
    @(posedge clk);
    snp <= 1'b0;
    cref(a0, 1'b0, 3'h7, 1'b1);
    chk(n_sys, 1);
    $display("uncached and snoop test done");
  endtask

  // Second strobe arrives while a read miss is still on the bus
  task automatic t_pipe;
    rst(1'b1);
    cref(a0, 1'b0, 3'h7, 1'b1);
    @(negedge clk);
    {n_sys, n_rdy, n_na, n_cale, n_bclk} = '0;
    @(posedge clk);
    as_n <= 1'b0;
    addr <= a0 ^ 30'h1000;
    @(posedge clk);
    as_n <= 1'b1;
    @(posedge clk);
    chk(na_n, 1'b0);
    as_n <= 1'b0;
    addr <= a0;
    @(posedge clk);
    as_n <= 1'b1;
    for (int i = 0; i < 40 && n_rdy < 2; i++) begin
      @(posedge clk);
    end
    if (n_rdy < 2) begin
      fails++;
      results();
    end
    repeat (2) @(posedge clk);
    chk(n_rdy, 2);
    chk(n_sys, 1);
    chk(n_cale, 2);
    $display("pipeline test done");
  endtask

  initial begin
    t_two_way();
    t_direct();
    t_write();
    t_misc();
    t_pipe();
    results();
  end
endmodule // wtcc_ctrl_test
